// *** rtl/ser_pkg.sv ***
// Constants and types shared by the status event reporting block.
package ser_pkg;

	localparam int STATUS_W    = 15;
	localparam int DATA_W      = 16;
	localparam int GROUPS      = 2;
	localparam int GRP_OP      = 0;
	localparam int GRP_QUES    = 1;
	localparam int SEL_W       = 4;
	localparam int SEL_GRP_BIT = 3;
	localparam int QUEUE_DEPTH = 8;
	localparam int QPTR_W      = 3;
	localparam int QCNT_W      = 4;

	// Preset and power-on contents of the configuration parts; queue full count and step values.
	localparam logic [STATUS_W-1:0] RISE_PRESET  = 15'h7FFF;
	localparam logic [STATUS_W-1:0] FALL_PRESET  = 15'h0000;
	localparam logic [STATUS_W-1:0] MASK_PRESET  = 15'h0000;
	localparam logic [STATUS_W-1:0] STATUS_ZERO  = 15'h0000;
	localparam logic [DATA_W-1:0]   ERR_NONE     = 16'h0000;
	localparam logic [QCNT_W-1:0]   QCNT_FULL    = 4'h8;
	localparam logic [QCNT_W-1:0]   QCNT_ONE     = 4'h1;
	localparam logic [QPTR_W-1:0]   QPTR_ONE     = 3'h1;

	// Adjustment failure bit of the questionable group.
	localparam int ADJ_FAIL_BIT = 0;

	// Low three bits of the command select; bit SEL_GRP_BIT picks the group.
	typedef enum logic [2:0] {
		PART_COND   = 3'h0,
		PART_MASK   = 3'h1,
		PART_EVT    = 3'h2,
		PART_FALL   = 3'h3,
		PART_RISE   = 3'h4,
		PART_PRESET = 3'h5,
		PART_QUEUE  = 3'h6,
		PART_NONE   = 3'h7
	} ser_part_t;

	typedef struct packed {
		logic [GROUPS-1:0][STATUS_W-1:0]    rise;
		logic [GROUPS-1:0][STATUS_W-1:0]    fall;
		logic [GROUPS-1:0][STATUS_W-1:0]    mask;
		logic [GROUPS-1:0][STATUS_W-1:0]    evt;
		logic [GROUPS-1:0][STATUS_W-1:0]    prev;
		logic                               primed;
		logic [QUEUE_DEPTH-1:0][DATA_W-1:0] q;
		logic [QPTR_W-1:0]                  rd;
		logic [QPTR_W-1:0]                  wr;
		logic [QCNT_W-1:0]                  cnt;
		logic                               rsp_valid;
		logic [DATA_W-1:0]                  rsp_data;
		logic [GROUPS-1:0]                  summary;
	} ser_state_t;

endpackage : ser_pkg

// *** rtl/ser_status.sv ***
// Operation and questionable status register groups with error queue.
`timescale 1ns/1ps
// Overview of operation
// - Instrument reset command leaves status parts alone; of the commands, only preset rewrites all filters and masks at once.
// - Every status part is 15 bits; reads and writes span 0 to 32767.
// - Condition reads return live hardware bits and change nothing.
// - Mask part picks which latched events feed the group summary bit.
// - Event read returns accumulated bits, then clears the event part except for edges seen in the read cycle.
// - Fall filter bit set and condition falls one to zero sets event bit.
// - Rise filter bit set and condition rises zero to one sets event bit.
// - Preset: rise filters all ones, fall filters zero, both masks zero.
// - Enabled true event drives summary bit high toward the higher status level.
// - Questionable bit zero flags adjustment failures; mask one routes them to summary.
// - Queue read returns and removes oldest entry; empty queue returns zero.
// - Positive codes are device errors, negative codes are command language errors.
module ser_status (
	input  wire logic                        ref_clk,
	input  wire logic                        reset,
	input  wire logic [ser_pkg::STATUS_W-1:0] op_cond,
	input  wire logic [ser_pkg::STATUS_W-1:0] ques_cond,
	input  wire logic                        cmd_valid,
	input  wire logic                        cmd_write,
	input  wire logic [ser_pkg::SEL_W-1:0]    cmd_sel,
	input  wire logic [ser_pkg::STATUS_W-1:0] cmd_wdata,
	input  wire logic                        err_push,
	input  wire logic [ser_pkg::DATA_W-1:0]   err_code,
	output logic                             rsp_valid,
	output logic [ser_pkg::DATA_W-1:0]        rsp_data,
	output logic                             op_summary,
	output logic                             ques_summary
);

	ser_pkg::ser_state_t s;
	ser_pkg::ser_state_t next_s;

	always_comb begin
		logic [ser_pkg::GROUPS-1:0][ser_pkg::STATUS_W-1:0] cond;
		logic [ser_pkg::STATUS_W-1:0]                      rise_hit;
		logic [ser_pkg::STATUS_W-1:0]                      fall_hit;
		logic [ser_pkg::STATUS_W-1:0]                      set_bits;
		ser_pkg::ser_part_t                                part;
		logic                                              grp;
		logic                                              rd_cmd;
		logic                                              wr_cmd;
		logic                                              pop;
		logic                                              push;
		cond     = '0;
		rise_hit = '0;
		fall_hit = '0;
		set_bits = '0;
		part     = ser_pkg::ser_part_t'(cmd_sel[2:0]);
		grp      = cmd_sel[ser_pkg::SEL_GRP_BIT];
		rd_cmd   = cmd_valid && !cmd_write;
		wr_cmd   = cmd_valid && cmd_write;
		pop      = 1'b0;
		push     = 1'b0;
		next_s   = s;
		cond[ser_pkg::GRP_OP]   = op_cond;
		cond[ser_pkg::GRP_QUES] = ques_cond;
		next_s.rsp_valid = cmd_valid;
		next_s.rsp_data  = ser_pkg::ERR_NONE;
		for (int g = 0; g < ser_pkg::GROUPS; g++) begin
			rise_hit = ~s.prev[g] & cond[g] & s.rise[g];
			fall_hit = s.prev[g] & ~cond[g] & s.fall[g];
			// The first cycle after reset only learns the condition, so bits
			// already high at power-up are not taken for rising edges.
			set_bits = s.primed ? (rise_hit | fall_hit) : ser_pkg::STATUS_ZERO;
			if (rd_cmd && grp == 1'(g) && part == ser_pkg::PART_EVT) begin
				next_s.evt[g] = set_bits;
			end else begin
				next_s.evt[g] = s.evt[g] | set_bits;
			end
			next_s.prev[g] = cond[g];
			if (wr_cmd && grp == 1'(g)) begin
				case (part)
					ser_pkg::PART_MASK: begin
						next_s.mask[g] = cmd_wdata;
					end
					ser_pkg::PART_FALL: begin
						next_s.fall[g] = cmd_wdata;
					end
					ser_pkg::PART_RISE: begin
						next_s.rise[g] = cmd_wdata;
					end
					default: begin
					end
				endcase
			end
		end
		next_s.primed = 1'b1;
		if (rd_cmd) begin
			case (part)
				ser_pkg::PART_COND: begin
					next_s.rsp_data = {1'b0, cond[grp]};
				end
				ser_pkg::PART_MASK: begin
					next_s.rsp_data = {1'b0, s.mask[grp]};
				end
				ser_pkg::PART_EVT: begin
					next_s.rsp_data = {1'b0, s.evt[grp]};
				end
				ser_pkg::PART_FALL: begin
					next_s.rsp_data = {1'b0, s.fall[grp]};
				end
				ser_pkg::PART_RISE: begin
					next_s.rsp_data = {1'b0, s.rise[grp]};
				end
				ser_pkg::PART_QUEUE: begin
					if (!grp && s.cnt != '0) begin
						next_s.rsp_data = s.q[s.rd];
						pop = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		// Preset is the only path besides power-on that rewrites all filters
		// and masks at once; a general instrument reset never reaches this block.
		if (wr_cmd && !grp && part == ser_pkg::PART_PRESET) begin
			for (int g = 0; g < ser_pkg::GROUPS; g++) begin
				next_s.rise[g] = ser_pkg::RISE_PRESET;
				next_s.fall[g] = ser_pkg::FALL_PRESET;
				next_s.mask[g] = ser_pkg::MASK_PRESET;
			end
		end
		// Code zero would read back as an empty queue, so it is not stored.
		// A full queue drops new entries; the oldest errors are kept.
		push = err_push && err_code != ser_pkg::ERR_NONE &&
			(s.cnt != ser_pkg::QCNT_FULL || pop);
		if (push) begin
			next_s.q[s.wr] = err_code;
			next_s.wr      = s.wr + ser_pkg::QPTR_ONE;
		end
		if (pop) begin
			next_s.rd = s.rd + ser_pkg::QPTR_ONE;
		end
		if (push && !pop) begin
			next_s.cnt = s.cnt + ser_pkg::QCNT_ONE;
		end else if (pop && !push) begin
			next_s.cnt = s.cnt - ser_pkg::QCNT_ONE;
		end
		// Built from the next values so the registered summary always matches
		// the event and mask contents held in the same cycle.
		for (int g = 0; g < ser_pkg::GROUPS; g++) begin
			next_s.summary[g] = |(next_s.evt[g] & next_s.mask[g]);
		end
		// Bit ADJ_FAIL_BIT of the questionable group takes part in the OR above.
		next_s.summary[ser_pkg::GRP_QUES] = next_s.summary[ser_pkg::GRP_QUES] |
			(next_s.evt[ser_pkg::GRP_QUES][ser_pkg::ADJ_FAIL_BIT] &
			next_s.mask[ser_pkg::GRP_QUES][ser_pkg::ADJ_FAIL_BIT]);
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (int g = 0; g < ser_pkg::GROUPS; g++) begin
				s.rise[g] <= ser_pkg::RISE_PRESET;
				s.fall[g] <= ser_pkg::FALL_PRESET;
				s.mask[g] <= ser_pkg::MASK_PRESET;
				s.evt[g]  <= ser_pkg::STATUS_ZERO;
				s.prev[g] <= ser_pkg::STATUS_ZERO;
			end
			s.primed    <= 1'b0;
			s.q         <= '0;
			s.rd        <= '0;
			s.wr        <= '0;
			s.cnt       <= '0;
			s.rsp_valid <= 1'b0;
			s.rsp_data  <= ser_pkg::ERR_NONE;
			s.summary   <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rsp_valid    = s.rsp_valid;
	assign rsp_data     = s.rsp_data;
	assign op_summary   = s.summary[ser_pkg::GRP_OP];
	assign ques_summary = s.summary[ser_pkg::GRP_QUES];

endmodule : ser_status

// *** test/ser_status_chk.sv ***
// Assertions on the command port and summary outputs of the status block.
`timescale 1ns/1ps
module ser_status_chk (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic [14:0] op_cond,
	input wire logic [14:0] ques_cond,
	input wire logic        cmd_valid,
	input wire logic        cmd_write,
	input wire logic [3:0]  cmd_sel,
	input wire logic [14:0] cmd_wdata,
	input wire logic        err_push,
	input wire logic [15:0] err_code,
	input wire logic        rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic        op_summary,
	input wire logic        ques_summary
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	answer_next_a: assert property (cmd_valid |=> rsp_valid) else $error("no answer");
	stray_answer_a: assert property (rsp_valid |-> $past(cmd_valid)) else $error("stray");
	idle_zero_a: assert property (!rsp_valid |-> rsp_data == 16'h0000) else $error("idle");
	data_range_a: assert property (rsp_valid && $past(cmd_sel) != 4'h6 |-> !rsp_data[15])
		else $error("read above range");
	live_op_a: assert property ($past(cmd_valid && !cmd_write && cmd_sel == 4'h0)
		|-> rsp_data == {1'b0, $past(op_cond)}) else $error("op state read");
	live_ques_a: assert property ($past(cmd_valid && !cmd_write && cmd_sel == 4'h8)
		|-> rsp_data == {1'b0, $past(ques_cond)}) else $error("ques state read");
	preset_quiet_a: assert property ($past(cmd_valid && cmd_write && cmd_sel == 4'h5)
		|-> !op_summary && !ques_summary) else $error("summary after preset");
	op_hold_a: assert property ($fell(op_summary) |-> $past(cmd_valid))
		else $error("op summary fell alone");
	ques_hold_a: assert property ($fell(ques_summary) |-> $past(cmd_valid))
		else $error("ques summary fell alone");
	cover property ($rose(op_summary));
	cover property ($rose(ques_summary));
	cover property (cmd_valid && cmd_sel == 4'h6);
endmodule : ser_status_chk
bind ser_status ser_status_chk i_chk (.ref_clk(ref_clk), .reset(reset), .op_cond(op_cond),
	.ques_cond(ques_cond), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel),
	.cmd_wdata(cmd_wdata), .err_push(err_push), .err_code(err_code), .rsp_valid(rsp_valid),
	.rsp_data(rsp_data), .op_summary(op_summary), .ques_summary(ques_summary));

// *** test/status_event_reporting_test.sv ***
// Self-checking bench for the status event reporting block.
`timescale 1ns/1ps
module status_event_reporting_test;
	logic        ref_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0;
	logic        err_push = 1'b0, rsp_valid, op_summary, ques_summary;
	logic [14:0] op_cond = 15'h0000, ques_cond = 15'h0000, cmd_wdata = 15'h0000;
	logic [3:0]  cmd_sel = 4'h0;
	logic [15:0] err_code = 16'h0000, rsp_data;
	int          errors = 0, samples_checked = 0, cycles = 0;
	always #50 ref_clk = ~ref_clk;
	ser_status i_dut (.ref_clk(ref_clk), .reset(reset), .op_cond(op_cond), .ques_cond(ques_cond),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
		.err_push(err_push), .err_code(err_code), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.op_summary(op_summary), .ques_summary(ques_summary));
	task automatic conclude();
		if (errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Every command is answered one cycle later, so the strobe is checked on each access.
	task automatic acc(input logic w, input logic [3:0] sel, input logic [14:0] d);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_sel <= sel;
		cmd_wdata <= d;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		#1;
		chk("answer", {15'h0000, rsp_valid}, 16'h0001);
	endtask : acc
	task automatic rd(input logic [3:0] sel, input logic [15:0] exp, input string what);
		acc(1'b0, sel, 15'h0000);
		chk(what, rsp_data, exp);
	endtask : rd
	task automatic push(input logic [15:0] c);
		@(posedge ref_clk);
		err_push <= 1'b1;
		err_code <= c;
		@(posedge ref_clk);
		err_push <= 1'b0;
	endtask : push
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		rd(4'h4, 16'h7FFF, "op rise");
		rd(4'h3, 16'h0000, "op fall");
		rd(4'h9, 16'h0000, "ques mask");
		acc(1'b1, 4'h4, 15'h0001);
		acc(1'b1, 4'h3, 15'h0004);
		rd(4'h3, 16'h0004, "fall readback");
		@(posedge ref_clk);
		op_cond <= 15'h0007;
		@(posedge ref_clk);
		op_cond <= 15'h0000;
		acc(1'b1, 4'h1, 15'h0002);
		chk("op summary off", {15'h0000, op_summary}, 16'h0000);
		acc(1'b1, 4'h1, 15'h0004);
		chk("op summary on", {15'h0000, op_summary}, 16'h0001);
		rd(4'h2, 16'h0005, "op events");
		chk("op summary cleared", {15'h0000, op_summary}, 16'h0000);
		rd(4'h2, 16'h0000, "op events reread");
		@(posedge ref_clk);
		op_cond <= 15'h1234;
		acc(1'b1, 4'h0, 15'h7FFF);
		rd(4'h0, 16'h1234, "op state");
		acc(1'b1, 4'h9, 15'h0001);
		@(posedge ref_clk);
		ques_cond <= 15'h0001;
		@(posedge ref_clk);
		#1;
		chk("ques summary", {15'h0000, ques_summary}, 16'h0001);
		rd(4'hA, 16'h0001, "ques events");
		push(16'h0005);
		push(16'hFF9C);
		rd(4'h6, 16'h0005, "queue first");
		rd(4'h6, 16'hFF9C, "queue second");
		push(16'h0000);
		rd(4'h6, 16'h0000, "queue empty");
		rd(4'h7, 16'h0000, "unmapped");
		acc(1'b1, 4'h5, 15'h0000);
		rd(4'h4, 16'h7FFF, "preset rise");
		rd(4'h3, 16'h0000, "preset fall");
		rd(4'h9, 16'h0000, "preset mask");
		// An edge in the cycle of the clearing read must survive the clear.
		fork
			rd(4'h2, 16'h0000, "op events at clear");
			begin
				@(posedge ref_clk);
				op_cond <= 15'h1235;
			end
		join
		rd(4'h2, 16'h0001, "op event kept");
		conclude();
	end
endmodule : status_event_reporting_test
